// ---- hw/indirect_addressing_status_flags.sv ----
`timescale 1ns/1ps
module indirect_addressing_status_flags #(
	parameter int AXI_ADDR_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire iaddr_pkg::core_req_t core_req,
	input wire iaddr_pkg::alu_req_t alu_req,
	output iaddr_pkg::core_rsp_t core_rsp,
	output logic [iaddr_pkg::DATA_W-1:0] alu_result,
	output logic [iaddr_pkg::FLAG_W-1:0] flags,
	output iaddr_pkg::mem_cmd_t mem_cmd,
	input wire logic [iaddr_pkg::DATA_W-1:0] mem_rdata,
	input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import iaddr_pkg::*;

	// Register offsets must fit the address width
	if (AXI_ADDR_W < 8)
	begin : g_bad_width
		$error("AXI_ADDR_W too small for the register map");
	end

	typedef struct packed {
		logic hit;
		logic [1:0] idx;
		port_sel_t sel;
	} port_hit_t;
	typedef struct packed {
		logic [NUM_PTR-1:0][ADDR_W-1:0] ptr;
		logic [FLAG_W-1:0] flags;
		logic [DATA_W-1:0] alu_result;
		mem_cmd_t mem;
		stage_t s1;
		stage_t s2;
		core_rsp_t rsp;
		logic aw_held;
		logic w_held;
		logic [AXI_ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_t;
	state_t st, next_state;

	// Port window decode, used for the request and for its target
	function automatic port_hit_t port_decode(input logic [ADDR_W-1:0] a);
		port_hit_t p;
		p.hit = (a[11:5] == PORT_BASE[11:5]) && (a[4:3] != PTR_IDX_NONE)
			&& (a[2:0] <= PORT_SEL_MAX);
		p.idx = a[4:3];
		p.sel = port_sel_t'(a[2:0]);
		return p;
	endfunction : port_decode

	// Flag values and affected mask of one ALU operation
	function automatic logic [DATA_W+2*FLAG_W-1:0] alu_eval(input alu_req_t r,
		input logic cin);
		logic [DATA_W-1:0] bop;
		logic [DATA_W:0] sum;
		logic [4:0] low;
		logic [DATA_W-1:0] res;
		logic [FLAG_W-1:0] f, m;
		bop = (r.op == ALU_SUB) ? ~r.b : r.b;
		sum = {1'b0, r.a} + {1'b0, bop} + {8'h00, r.op == ALU_SUB};
		low = {1'b0, r.a[3:0]} + {1'b0, bop[3:0]} + {4'h0, r.op == ALU_SUB};
		res = sum[DATA_W-1:0];
		f = FLAG_RESET;
		m = FLAG_RESET;
		case (r.op)
			ALU_ADD, ALU_SUB:
			begin
				m = MASK_ALL;
				f[FLAG_C] = sum[DATA_W];
				f[FLAG_DC] = low[4];
				f[FLAG_OV] = (r.a[7] == bop[7]) && (res[7] != r.a[7]);
			end
			ALU_LOGIC:
			begin
				m = MASK_NZ;
				res = r.logic_result;
			end
			ALU_ROT_LEFT:
			begin
				m = MASK_ROT;
				res = {r.a[6:0], cin};
				f[FLAG_C] = r.a[7];
				f[FLAG_DC] = r.a[3];
			end
			ALU_ROT_RIGHT:
			begin
				m = MASK_ROT;
				res = {cin, r.a[7:1]};
				f[FLAG_C] = r.a[0];
				f[FLAG_DC] = r.a[4];
			end
			default: m = FLAG_RESET;
		endcase
		f[FLAG_N] = res[7];
		f[FLAG_Z] = (res == 8'h00);
		return {res, f, m};
	endfunction : alu_eval

	port_hit_t req_port, tgt_port;
	logic [ADDR_W-1:0] base, eff_addr;
	logic loop_hit, ptr_byte_hit, flag_hit, axi_wr_now;
	logic [1:0] ptr_byte_idx;
	logic [DATA_W-1:0] alu_res;
	logic [FLAG_W-1:0] alu_flags, alu_mask;
	// Address formation for the current core request
	assign req_port = port_decode(core_req.addr);
	assign base = st.ptr[req_port.idx];
	always_comb
	begin
		eff_addr = core_req.addr;
		if (req_port.hit)
			case (req_port.sel)
				SEL_PRE_INC: eff_addr = base + PTR_STEP;
				SEL_INDEXED: eff_addr = base + {{4{core_req.working_register[7]}},
					core_req.working_register};
				default: eff_addr = base;
			endcase
	end
	assign tgt_port = port_decode(eff_addr);
	assign loop_hit = req_port.hit && tgt_port.hit;
	assign ptr_byte_hit = (eff_addr[11:3] == PTR_BASE[11:3])
		&& (eff_addr[2:1] != PTR_IDX_NONE);
	assign ptr_byte_idx = eff_addr[2:1];
	assign flag_hit = (eff_addr == FLAG_ADDR);
	assign {alu_res, alu_flags, alu_mask} = alu_eval(alu_req, st.flags[FLAG_C]);
	assign axi_wr_now = st.aw_held && st.w_held && !st.bvalid;

	// Next-state logic
	always_comb
	begin
		next_state = st;
		next_state.mem.valid = 1'b0;
		next_state.s1 = '0;
		next_state.s2 = st.s1;
		// Read answer three edges after the request
		next_state.rsp.valid = st.s2.valid;
		if (st.s2.valid)
			next_state.rsp.data = st.s2.from_mem ? mem_rdata : st.s2.data;
		// ALU flags, held back by a write that loops onto a port
		if (!(core_req.valid && core_req.write && loop_hit))
		begin
			next_state.flags = (st.flags & ~alu_mask) | (alu_flags & alu_mask);
			if (alu_req.op != ALU_NONE)
				next_state.alu_result = alu_res;
		end
		// Pointer stepping, flags untouched
		if (core_req.valid && req_port.hit)
			case (req_port.sel)
				SEL_POST_DEC: next_state.ptr[req_port.idx] = base - PTR_STEP;
				SEL_POST_INC: next_state.ptr[req_port.idx] = base + PTR_STEP;
				SEL_PRE_INC: next_state.ptr[req_port.idx] = eff_addr;
				default: next_state.ptr[req_port.idx] = base;
			endcase
		// Data access
		if (core_req.valid)
		begin
			if (loop_hit)
			begin
				if (!core_req.write)
				begin
					next_state.s1 = '{valid: 1'b1, from_mem: 1'b0, data: 8'h00};
					next_state.flags[FLAG_Z] = 1'b1;
				end
			end
			else if (ptr_byte_hit)
			begin
				if (core_req.write)
					next_state.ptr[ptr_byte_idx] = st.ptr[ptr_byte_idx];
				if (core_req.write && eff_addr[0])
					next_state.ptr[ptr_byte_idx][11:8] = core_req.wdata[3:0];
				else if (core_req.write)
					next_state.ptr[ptr_byte_idx][7:0] = core_req.wdata;
				else
					next_state.s1 = '{valid: 1'b1, from_mem: 1'b0,
						data: eff_addr[0] ? {4'h0, st.ptr[ptr_byte_idx][11:8]}
						: st.ptr[ptr_byte_idx][7:0]};
			end
			else if (flag_hit)
			begin
				if (core_req.write)
					next_state.flags = (core_req.wdata[FLAG_W-1:0] & ~alu_mask)
						| (next_state.flags & alu_mask);
				else
					next_state.s1 = '{valid: 1'b1, from_mem: 1'b0,
						data: {3'h0, st.flags}};
			end
			else
			begin
				next_state.mem = '{valid: 1'b1, write: core_req.write,
					addr: eff_addr, wdata: core_req.wdata};
				next_state.s1 = '{valid: !core_req.write, from_mem: 1'b1,
					data: 8'h00};
			end
		end
		// Bus write channel capture
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_state.aw_held = 1'b1;
			next_state.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_state.w_held = 1'b1;
			next_state.wdata = s_axi_wdata;
			next_state.wstrb = s_axi_wstrb;
		end
		// Bus write takes effect after the core's own updates
		if (axi_wr_now)
		begin
			next_state.aw_held = 1'b0;
			next_state.w_held = 1'b0;
			next_state.bvalid = 1'b1;
			next_state.bresp = RESP_OKAY;
			case (st.awaddr[7:0] & 8'hFC)
				OFF_PTR0, OFF_PTR1, OFF_PTR2:
				begin
					if (st.wstrb[0])
						next_state.ptr[st.awaddr[3:2]][7:0] = st.wdata[7:0];
					if (st.wstrb[1])
						next_state.ptr[st.awaddr[3:2]][11:8] = st.wdata[11:8];
				end
				OFF_FLAGS:
					if (st.wstrb[0])
						next_state.flags = st.wdata[FLAG_W-1:0];
				default: next_state.bresp = RESP_SLVERR;
			endcase
			if (st.awaddr[AXI_ADDR_W-1:4] != '0)
				next_state.bresp = RESP_SLVERR;
		end
		if (st.bvalid && s_axi_bready)
			next_state.bvalid = 1'b0;
		// Bus read channel
		if (st.rvalid && s_axi_rready)
			next_state.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_state.rvalid = 1'b1;
			next_state.rresp = RESP_OKAY;
			next_state.rdata = 32'h0000_0000;
			case (s_axi_araddr[7:0] & 8'hFC)
				OFF_PTR0, OFF_PTR1, OFF_PTR2:
					next_state.rdata[ADDR_W-1:0] = st.ptr[s_axi_araddr[3:2]];
				OFF_FLAGS: next_state.rdata[FLAG_W-1:0] = st.flags;
				default: next_state.rresp = RESP_SLVERR;
			endcase
			if (s_axi_araddr[AXI_ADDR_W-1:4] != '0)
				next_state.rresp = RESP_SLVERR;
		end
	end

	// State register
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st <= '0;
			st.ptr <= {NUM_PTR{PTR_RESET}};
			st.flags <= FLAG_RESET;
		end
		else
			st <= next_state;
	end

	// Outputs
	assign core_rsp = st.rsp;
	assign alu_result = st.alu_result;
	assign flags = st.flags;
	assign mem_cmd = st.mem;
	assign s_axi_awready = !st.aw_held && !st.bvalid;
	assign s_axi_wready = !st.w_held && !st.bvalid;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Checks on addressing and flags
	a_plain_port_map: assert property (core_req.valid && req_port.hit
		&& req_port.sel == SEL_PLAIN && !tgt_port.hit && !ptr_byte_hit
		&& !flag_hit |=> mem_cmd.valid && mem_cmd.addr == $past(base))
		else $error("plain port did not reach pointed byte");
	a_loop_read_zero: assert property (core_req.valid && !core_req.write
		&& loop_hit |=> flags[FLAG_Z] ##2 core_rsp.valid && core_rsp.data == 8'h00)
		else $error("looped read did not return zero");
	a_loop_write_nop: assert property (core_req.valid && core_req.write
		&& loop_hit && !axi_wr_now |=> !mem_cmd.valid && $stable(flags))
		else $error("looped write had an effect");
	a_post_inc_step: assert property (core_req.valid && req_port.hit
		&& req_port.sel == SEL_POST_INC && !axi_wr_now
		&& !(core_req.write && ptr_byte_hit)
		|=> st.ptr[$past(req_port.idx)] == $past(base) + PTR_STEP)
		else $error("post increment wrong");
	a_post_dec_step: assert property (core_req.valid && req_port.hit
		&& req_port.sel == SEL_POST_DEC && !axi_wr_now
		&& !(core_req.write && ptr_byte_hit)
		|=> st.ptr[$past(req_port.idx)] == $past(base) - PTR_STEP)
		else $error("post decrement wrong");
	a_pre_inc_addr: assert property (core_req.valid && req_port.hit
		&& req_port.sel == SEL_PRE_INC && !tgt_port.hit && !ptr_byte_hit
		&& !flag_hit && !axi_wr_now |=> mem_cmd.addr == $past(base) + PTR_STEP
		&& st.ptr[$past(req_port.idx)] == mem_cmd.addr)
		else $error("pre increment wrong");
	a_indexed_hold: assert property (core_req.valid && req_port.hit
		&& req_port.sel == SEL_INDEXED && !ptr_byte_hit && !axi_wr_now
		|=> st.ptr[$past(req_port.idx)] == $past(base))
		else $error("indexed access moved pointer");
	a_flag_protect: assert property (core_req.valid && core_req.write
		&& flag_hit && !loop_hit && alu_req.op == ALU_ADD && !axi_wr_now
		|=> flags == $past(alu_flags))
		else $error("flag write not blocked");
	a_step_no_flags: assert property (core_req.valid && req_port.hit
		&& !loop_hit && !flag_hit && alu_req.op == ALU_NONE && !axi_wr_now
		|=> $stable(flags))
		else $error("pointer step changed flags");
	a_negative_zero: assert property (alu_req.op == ALU_LOGIC
		&& !(core_req.valid && (loop_hit || flag_hit)) && !axi_wr_now
		|=> flags[FLAG_N] == $past(alu_req.logic_result[7])
		&& flags[FLAG_Z] == ($past(alu_req.logic_result) == 8'h00))
		else $error("negative or zero flag wrong");
endmodule : indirect_addressing_status_flags

// ---- common/iaddr_pkg.sv ----
package iaddr_pkg;
	// Core data space
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int NUM_PTR = 3;
	localparam logic [ADDR_W-1:0] PTR_STEP = 12'h001;
	// Core-side addresses of the ports, pointer bytes and flag register
	localparam logic [ADDR_W-1:0] PORT_BASE = 12'hFC0;
	localparam logic [2:0] PORT_SEL_MAX = 3'h4;
	localparam logic [1:0] PTR_IDX_NONE = 2'h3;
	localparam logic [ADDR_W-1:0] PTR_BASE = 12'hFE0;
	localparam logic [ADDR_W-1:0] FLAG_ADDR = 12'hFF0;
	// Flag positions in the flag register
	localparam int FLAG_W = 5;
	localparam int FLAG_C = 0;
	localparam int FLAG_DC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_N = 4;
	localparam logic [FLAG_W-1:0] FLAG_RESET = 5'h00;
	localparam logic [FLAG_W-1:0] MASK_ALL = 5'h1F;
	localparam logic [FLAG_W-1:0] MASK_NZ = 5'h14;
	localparam logic [FLAG_W-1:0] MASK_ROT = 5'h17;
	localparam logic [ADDR_W-1:0] PTR_RESET = 12'h000;
	// Bus register offsets and responses
	localparam logic [7:0] OFF_PTR0 = 8'h00;
	localparam logic [7:0] OFF_PTR1 = 8'h04;
	localparam logic [7:0] OFF_PTR2 = 8'h08;
	localparam logic [7:0] OFF_FLAGS = 8'h0C;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {SEL_PLAIN, SEL_POST_DEC, SEL_POST_INC,
		SEL_PRE_INC, SEL_INDEXED} port_sel_t;
	typedef enum logic [2:0] {ALU_NONE, ALU_ADD, ALU_SUB, ALU_LOGIC,
		ALU_ROT_LEFT, ALU_ROT_RIGHT} alu_op_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] working_register;
	} core_req_t;
	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] data;
	} core_rsp_t;
	typedef struct packed {
		logic valid;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} mem_cmd_t;
	typedef struct packed {
		alu_op_t op;
		logic [DATA_W-1:0] a;
		logic [DATA_W-1:0] b;
		logic [DATA_W-1:0] logic_result;
	} alu_req_t;
	typedef struct packed {
		logic valid;
		logic from_mem;
		logic [DATA_W-1:0] data;
	} stage_t;
endpackage : iaddr_pkg

// ---- dv/data_mem_model.sv ----
`timescale 1ns/1ps
module data_mem_model (
	input wire logic aclk,
	input wire iaddr_pkg::mem_cmd_t mem_cmd,
	output logic [iaddr_pkg::DATA_W-1:0] mem_rdata
);
	import iaddr_pkg::*;
	logic [DATA_W-1:0] mem [0:4095];

	// Known contents so that addresses with distinct low bytes read back distinct bytes
	initial
	begin
		for (int i = 0; i < 4096; i++)
			mem[i] = 8'(i) ^ 8'hA5;
	end

	// Stores writes; answers a read in the cycle after its command
	// Between answers the read bus toggles so stale data never matches
	always @(posedge aclk)
	begin
		if (mem_cmd.valid && mem_cmd.write)
			mem[mem_cmd.addr] <= mem_cmd.wdata;
		if (mem_cmd.valid && !mem_cmd.write)
			mem_rdata <= mem[mem_cmd.addr];
		else
			mem_rdata <= ~mem_rdata;
	end
endmodule : data_mem_model

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
	import iaddr_pkg::*;
	logic aclk;
	logic aresetn;
	core_req_t core_req;
	alu_req_t alu_req;
	core_rsp_t core_rsp;
	logic [7:0] alu_result;
	logic [4:0] flags;
	mem_cmd_t mem_cmd;
	logic [7:0] mem_rdata;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	int fails, total_checks;
	// Ports of pointer 0 walked from 0FFh: address used, pointer after
	logic [11:0] sel_addr [5] = '{12'hFC2, 12'hFC1, 12'hFC3, 12'hFC0, 12'hFC4};
	logic [11:0] acc_addr [5] = '{12'h0FF, 12'h100, 12'h100, 12'h100, 12'h0FE};
	logic [11:0] ptr_after [5] = '{12'h100, 12'h0FF, 12'h100, 12'h100, 12'h100};
	logic [7:0] working_register_tab [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFE};
	// ALU steps in order; later rows depend on the flags left before
	alu_req_t alu_tab [7] = '{'{ALU_ADD, 8'h7F, 8'h01, 8'h00},
		'{ALU_ADD, 8'hFF, 8'h01, 8'h00}, '{ALU_SUB, 8'h00, 8'h01, 8'h00},
		'{ALU_SUB, 8'h80, 8'h01, 8'h00}, '{ALU_ROT_LEFT, 8'h88, 8'h00, 8'h00},
		'{ALU_ROT_RIGHT, 8'h01, 8'h00, 8'h00}, '{ALU_LOGIC, 8'h00, 8'h00, 8'h00}};
	logic [12:0] alu_exp [7] = '{{8'h80, 5'h1A}, {8'h00, 5'h07}, {8'hFF, 5'h10},
		{8'h7F, 5'h09}, {8'h11, 5'h0B}, {8'h80, 5'h19}, {8'h00, 5'h0D}};

	indirect_addressing_status_flags #(.AXI_ADDR_W(8)) i_dut (
		.aclk, .aresetn, .core_req, .alu_req, .core_rsp, .alu_result,
		.flags, .mem_cmd, .mem_rdata, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready
	);
	data_mem_model i_mem (.aclk, .mem_cmd, .mem_rdata);

	function automatic logic [7:0] pat(input logic [11:0] a);
		return a[7:0] ^ 8'hA5;
	endfunction : pat

	task chk(input logic [39:0] seen, input logic [39:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task results;
		if (fails == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	// One core request and ALU operation, held for a single edge
	task step(input core_req_t c, input alu_req_t a);
		@(posedge aclk);
		core_req <= c;
		alu_req <= a;
		@(posedge aclk);
		core_req.valid <= 1'b0;
		alu_req.op <= ALU_NONE;
		#1;
	endtask : step

	task core_wr(input logic [11:0] a, input logic [7:0] d, input alu_req_t al);
		step(core_req_t'{1'b1, 1'b1, a, d, 8'h00}, al);
	endtask : core_wr

	task core_rd(input logic [11:0] a, input logic [7:0] w, input logic [7:0] e);
		step(core_req_t'{1'b1, 1'b0, a, 8'h00, w}, '0);
		for (int n = 0; n < 8 && core_rsp.valid !== 1'b1; n++)
			@(posedge aclk) #1;
		chk({core_rsp.valid, core_rsp.data}, {1'b1, e});
	endtask : core_rd

	task axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY);
		logic aw, w, b;
		logic [1:0] r;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b = 1'b0;
		while (!b)
		begin
			#1;
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		chk(r, er);
	endtask : axi_wr

	task axi_rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er = RESP_OKAY);
		logic ar, r;
		logic [33:0] got;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		r = 1'b0;
		while (!r)
		begin
			#1;
			ar = s_axi_arvalid & s_axi_arready;
			r = s_axi_rvalid;
			got = {s_axi_rresp, s_axi_rdata};
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		chk(got, {er, e});
	endtask : axi_rd

	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// Watchdog against a hung handshake
	initial
	begin
		repeat (5000) @(posedge aclk);
		fails++;
		results();
	end

	initial
	begin
		fails = 0;
		total_checks = 0;
		aresetn = 1'b0;
		core_req = '0;
		alu_req = '0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready,
			s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values, pointer width, unmapped offset
		axi_rd(OFF_PTR0, 32'h0);
		axi_rd(OFF_FLAGS, 32'h0);
		axi_rd(8'h10, 32'h0, RESP_SLVERR);
		axi_wr(8'h10, 32'h1, RESP_SLVERR);
		axi_wr(OFF_PTR2, 32'hFFFFFFFF);
		axi_rd(OFF_PTR2, 32'h00000FFF);
		// All five ports of pointer 0 across the byte boundary
		axi_wr(OFF_PTR0, 32'h0FF);
		for (int i = 0; i < 5; i++)
		begin
			core_rd(sel_addr[i], working_register_tab[i], pat(acc_addr[i]));
			axi_rd(OFF_PTR0, {20'h0, ptr_after[i]});
		end
		// Post-increment write through pointer 1
		axi_wr(OFF_PTR1, 32'h200);
		core_wr(12'hFCA, 8'h5A, '0);
		axi_rd(OFF_PTR1, 32'h201);
		chk(i_mem.mem[12'h200], 8'h5A);
		// Pointer stepping down to zero leaves zero flag clear
		axi_wr(OFF_FLAGS, 32'h0);
		axi_wr(OFF_PTR0, 32'h1);
		core_rd(12'hFC1, 8'h00, pat(12'h001));
		axi_rd(OFF_PTR0, 32'h0);
		chk(flags, 5'h00);
		// Pointer 2 aimed at a port: zero read, write and ALU update dropped
		axi_wr(OFF_PTR2, 32'hFC0);
		core_rd(12'hFD0, 8'h00, 8'h00);
		chk(flags, 5'h04);
		core_wr(12'hFD0, 8'h77, alu_tab[0]);
		repeat (3) @(posedge aclk);
		chk(flags, 5'h04);
		chk(i_mem.mem[12'hFC0], pat(12'hFC0));
		// Write into the pointer's own high byte beats its step
		axi_wr(OFF_PTR0, 32'hFE1);
		core_wr(12'hFC2, 8'h0B, '0);
		axi_rd(OFF_PTR0, 32'hBE1);
		// Pointer bytes read and written directly from the core side
		core_rd(12'hFE1, 8'h00, 8'h0B);
		core_wr(12'hFE0, 8'h34, '0);
		axi_rd(OFF_PTR0, 32'hB34);
		// ALU flag table
		for (int i = 0; i < 7; i++)
		begin
			step('0, alu_tab[i]);
			chk({alu_result, flags}, alu_exp[i]);
		end
		// Core writes to the flag register, alone and beside an ALU update
		core_wr(FLAG_ADDR, 8'h15, '0);
		chk(flags, 5'h15);
		core_wr(FLAG_ADDR, 8'h00, alu_tab[0]);
		chk({alu_result, flags}, alu_exp[0]);
		axi_rd(OFF_FLAGS, 32'h1A);
		core_rd(FLAG_ADDR, 8'h00, 8'h1A);
		results();
	end
endmodule : tb
